// >>> hw/adc_link_if.sv
// Pin bundle between the converter end and the capturing host end.
// Assumes every pin is a plain point-to-point wire; no tri-state.
`timescale 1ns/100ps
interface adc_link_if;
  logic       convert_strobe_n;
  logic       shift_clock;
  logic       shift_clock_p;
  logic       shift_clock_n;
  logic       rate_select;
  logic       echo_disable;
  logic       io_select;
  logic [3:0] lane_out;
  logic [3:0] pair_out_p;
  logic [3:0] pair_out_n;
  logic       echoed_shift_clock;
  logic       echo_p;
  logic       echo_n;

  modport device (
    input  convert_strobe_n, shift_clock, shift_clock_p, shift_clock_n,
    input  rate_select, echo_disable, io_select,
    output lane_out, pair_out_p, pair_out_n, echoed_shift_clock, echo_p, echo_n
  );
  modport host (
    output convert_strobe_n, shift_clock, shift_clock_p, shift_clock_n,
    output rate_select, echo_disable, io_select,
    input  lane_out, pair_out_p, pair_out_n, echoed_shift_clock, echo_p, echo_n
  );
endinterface : adc_link_if

// >>> hw/adc_link_pkg.sv
// Shared constants and types for the quad converter serial link.
// Assumes a single 200 MHz system clock on both ends.
package adc_link_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int POR_WAIT_MS     = 10;
  localparam int POR_WAIT_CYC    = POR_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_NS  = 30;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC    = 8;
  localparam int CONV_WAIT_CYC   = 8;
  localparam int DRAIN_CYC       = 8;

  // ==========================================================
  // Low-power pulse counts
  localparam logic [2:0] PULSES_TO_NAP   = 3'h2;
  localparam logic [2:0] PULSES_TO_SLEEP = 3'h4;
  localparam logic [2:0] PULSES_TO_WAKE  = 3'h5;

  // ==========================================================
  // Controller register map
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] RESULT_OFS  = 8'h10;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam int CTRL_CONV_BIT   = 0;
  localparam int CTRL_PULSE_BIT  = 1;
  localparam int CTRL_WAKE_BIT   = 2;
  localparam int CTRL_RATE_BIT   = 3;
  localparam int CTRL_ECHO_BIT   = 4;
  localparam int CTRL_DIFF_BIT   = 5;
  localparam int CTRL_LANES_LSB  = 6;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_LOCK_BIT   = 1;
  localparam int STAT_FRAMES_LSB = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // State types
  typedef enum logic [1:0] {PWR_OP, PWR_NAP, PWR_SLEEP} power_t;
  typedef enum logic [2:0] {H_IDLE, H_STROBE, H_CONV, H_CLOCK, H_DRAIN, H_WAKE} host_state_t;

endpackage : adc_link_pkg

// >>> hw/adc_readout_device.sv
// Converter end of the link: strobe-driven conversion, lane shifting,
// echoed clock, supply reset and nap/sleep control by pulse counting.
// Assumes the host paces everything with its shift clock; no clock here
// other than mclk_i, which oversamples the link pins.
//
// Functional notes
// - Supply drop resets, then timed reinitialisation.
// - Host waits 10 ms after power reset.
// - Strobe rise samples, strobe fall converts.
// - Host shift clock paces all shifting.
// - Host strobe high pulse about 30 ns.
// - Single rate shifts on falling edges.
// - Host supplies 110 MHz for SDR; this host drives 12.5 MHz (8-cycle half period).
// - Double rate shifts on both edges.
// - Host supplies 55 MHz for DDR; this host drives the same 12.5 MHz as for SDR.
// - Echoed clock copies shift clock, aligned.
// - SDR data changes on echo falling.
// - DDR receiver captures both echo edges.
// - Echo disable pin silences echoed clock.
// - Two strobes, static clock, enter nap.
// - One shift rising edge leaves nap.
// - Two more strobes move nap to sleep.
// - Single-ended wake by edge, 10 ms wait.
// - Fifth strobe wakes from sleep always.
// - Strobes alone cycle power states endlessly.
// - I/O select picks single-ended or differential.
// - Lanes rotate channels starting at own.
// - Host gives 64 or 32 over lanes cycles.
`timescale 1ns/100ps
module adc_readout_device
  import adc_link_pkg::*;
#(
  parameter int REINIT_CYCLES = POR_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Converter core side
  input  wire logic [63:0] ch_data_i,
  input  wire logic        supply_ok_i,
  output logic      [1:0]  power_state_o,
  output logic             reinit_busy_o,
  // Link pins
  adc_link_if.device       link
);

  // ==========================================================
  // Lane bit picker
  // Lane j shows channel j+p[5:4] (mod 4), bit 15-p[3:0]
  function automatic logic [3:0] lane_bits(input logic [63:0] r, input logic [5:0] p);
    logic [1:0] ch;
    lane_bits = 4'h0;
    for (int j = 0; j < 4; j++) begin
      ch = 2'(j) + p[5:4];
      lane_bits[j] = r[{ch, ~p[3:0]}];
    end
  endfunction : lane_bits

  // ==========================================================
  // Pin synchronisation
  logic [5:0] pin_s;
  logic [5:0] pin_r;
  logic [5:0] pin_f;
  logic       sck_pin;

  assign sck_pin = link.io_select ? link.shift_clock_p : link.shift_clock;

  sync_edge #(.W(6)) u_pins (
    .mclk_i   (mclk_i),
    .nrst_i   (nrst_i),
    .d_i      ({supply_ok_i, link.io_select, link.echo_disable, link.rate_select,
                sck_pin, link.convert_strobe_n}),
    .q_o      (pin_s),
    .q_prev_o (),
    .rise_o   (pin_r),
    .fall_o   (pin_f)
  );

  // Named views of the synchronised pins
  wire str_rise  = pin_r[0];
  wire str_fall  = pin_f[0];
  wire sck_s     = pin_s[1];
  wire sck_rise  = pin_r[1];
  wire sck_fall  = pin_f[1];
  wire ddr       = pin_s[2];
  wire echo_off  = pin_s[3];
  wire diff      = pin_s[4];
  wire supply_ok = pin_s[5];

  // ==========================================================
  // State
  power_t      power_reg;
  power_t      power_next;
  logic [2:0]  pulses_reg;
  logic [2:0]  pulses_next;
  logic [63:0] result_reg;
  logic [63:0] result_next;
  logic [5:0]  pos_reg;
  logic [5:0]  pos_next;
  logic [31:0] reinit_reg;
  logic        sampling_reg;
  logic [3:0]  lane_reg;
  logic [3:0]  pair_p_reg;
  logic [3:0]  pair_n_reg;
  logic        echo_reg;
  logic        echo_p_reg;
  logic        echo_n_reg;

  // ==========================================================
  // Power-state sequencing
  // A rising shift edge wins over a strobe in the same cycle
  always_comb begin
    power_next  = power_reg;
    pulses_next = pulses_reg;
    if (sck_rise) begin
      if (!(power_reg == PWR_SLEEP && diff)) begin
        pulses_next = 3'h0;
        power_next  = PWR_OP;
      end
    end else if (str_rise) begin
      pulses_next = pulses_reg + 3'h1;
      case (power_reg)
        PWR_OP: begin
          if (pulses_next == PULSES_TO_NAP) begin
            power_next = PWR_NAP;
          end
        end
        PWR_NAP: begin
          if (pulses_next == PULSES_TO_SLEEP) begin
            power_next = PWR_SLEEP;
          end
        end
        default: begin
          if (pulses_next == PULSES_TO_WAKE) begin
            power_next  = PWR_OP;
            pulses_next = 3'h0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Conversion and shifting decisions
  wire powered  = (power_reg == PWR_OP) && supply_ok;
  wire reinit   = (reinit_reg != 32'h0);
  wire conv_go  = str_fall && powered && sampling_reg;
  // shifting only on host clock edges
  wire shift_go = !conv_go && powered && (ddr ? (sck_rise || sck_fall) : sck_fall);
  // results during reinitialisation are invalid, sent as zero
  wire [63:0] conv_data = reinit ? 64'h0 : ch_data_i;

  assign result_next = conv_go ? conv_data : result_reg;
  // position wraps so channels rotate forever
  assign pos_next    = conv_go ? 6'h0 : (shift_go ? pos_reg + 6'h1 : pos_reg);

  // ==========================================================
  // Core registers
  // supply drop clears state and reloads the reinit timer
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_reg    <= PWR_OP;
      pulses_reg   <= 3'h0;
      result_reg   <= 64'h0;
      pos_reg      <= 6'h0;
      sampling_reg <= 1'b0;
      reinit_reg   <= 32'(REINIT_CYCLES);
    end else if (!supply_ok) begin
      power_reg    <= PWR_OP;
      pulses_reg   <= 3'h0;
      result_reg   <= 64'h0;
      pos_reg      <= 6'h0;
      sampling_reg <= 1'b0;
      reinit_reg   <= 32'(REINIT_CYCLES);
    end else begin
      power_reg    <= power_next;
      pulses_reg   <= pulses_next;
      result_reg   <= result_next;
      pos_reg      <= pos_next;
      sampling_reg <= str_rise ? 1'b1 : (str_fall ? 1'b0 : sampling_reg);
      reinit_reg   <= reinit ? reinit_reg - 32'h1 : 32'h0;
    end
  end

  // ==========================================================
  // Output pins
  // Data and echo both load from the same synced sample, keeping them aligned
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lane_reg   <= 4'h0;
      pair_p_reg <= 4'h0;
      pair_n_reg <= 4'h0;
      echo_reg   <= 1'b0;
      echo_p_reg <= 1'b0;
      echo_n_reg <= 1'b0;
    end else begin
      lane_reg   <= diff ? 4'h0 : lane_bits(result_next, pos_next);
      pair_p_reg <= diff ? lane_bits(result_next, pos_next) : 4'h0;
      pair_n_reg <= diff ? ~lane_bits(result_next, pos_next) : 4'h0;
      echo_reg   <= !echo_off && !diff && sck_s;
      echo_p_reg <= !echo_off && diff && sck_s;
      echo_n_reg <= !echo_off && diff && !sck_s;
    end
  end

  // Pin and status drive
  assign link.lane_out           = lane_reg;
  assign link.pair_out_p         = pair_p_reg;
  assign link.pair_out_n         = pair_n_reg;
  assign link.echoed_shift_clock = echo_reg;
  assign link.echo_p             = echo_p_reg;
  assign link.echo_n             = echo_n_reg;
  assign power_state_o           = power_reg;

  // Busy while supply is low or reinit counts
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reinit_busy_o <= 1'b1;
    end else begin
      reinit_busy_o <= !supply_ok || (reinit_reg > 32'h1) || (reinit && !(reinit_reg == 32'h1));
    end
  end

endmodule : adc_readout_device

// >>> hw/adc_readout_host.sv
// Host end: AXI4-Lite controller that strobes the converter, drives the
// shift clock, captures lanes on the echoed clock and sends nap/wake.
// Assumes the converter end sits on the link interface.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module adc_readout_host
  import adc_link_pkg::*;
#(
  parameter int LOCK_CYCLES = POR_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link pins
  adc_link_if.host         link
);

  // ==========================================================
  // Word of channel c from the lane shift registers
  function automatic logic [15:0] word_of(input logic [255:0] s, input logic [1:0] c, input logic [1:0] lm);
    int g;
    int w;
    int base;
    g = 1 << lm;
    w = c % g;
    base = 64 * (c - w) + 16 * (g - w) - 1;
    word_of = s[base -: 16];
  endfunction : word_of

  // ==========================================================
  // AXI write and read channels
  logic [7:0]  awaddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        aw_got;
  logic        w_got;
  logic [7:0]  cfg_reg;
  logic [2:0]  cmd_reg;
  logic [63:0] res_reg;
  logic [7:0]  frames_reg;
  logic [31:0] lock_reg;
  host_state_t st_reg;
  host_state_t st_next;

  wire aw_hs   = s_axi_awvalid && s_axi_awready;
  wire w_hs    = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_got && w_got && !s_axi_bvalid;
  wire ctrl_wr = do_wr && (awaddr_reg == CTRL_OFS) && wstrb0_reg;
  wire wr_hit  = (awaddr_reg == CTRL_OFS) || (awaddr_reg == STATUS_OFS);
  wire ar_hs   = s_axi_arvalid && s_axi_arready;
  wire locked  = (lock_reg != 32'h0);

  // Read decode
  logic [31:0] rd_data;
  logic        rd_hit;
  wire  [7:0]  ridx = s_axi_araddr - RESULT_OFS;
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0;
    if (s_axi_araddr == CTRL_OFS) begin
      rd_data = {24'h0, cfg_reg};
    end else if (s_axi_araddr == STATUS_OFS) begin
      rd_data = {16'h0, frames_reg, 6'h0, locked, st_reg != H_IDLE};
    end else if (s_axi_araddr >= RESULT_OFS && ridx < 8'h10 && ridx[1:0] == 2'h0) begin
      rd_data = {16'h0, res_reg[{ridx[3:2], 4'h0} +: 16]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Address and data taken in either order, response after both
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      awaddr_reg    <= 8'h0;
      wdata_reg     <= 8'h0;
      wstrb0_reg    <= 1'b0;
    end else begin
      if (aw_hs) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        wdata_reg    <= s_axi_wdata[7:0];
        wstrb0_reg   <= s_axi_wstrb[0];
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Echo and lane capture
  logic [4:0]   cap_s;
  logic [4:0]   cap_p;
  logic [4:0]   cap_r;
  logic [4:0]   cap_f;
  logic [255:0] sr_reg;
  logic [1:0]   lm;
  logic [6:0]   bits;

  assign lm   = (cfg_reg[CTRL_LANES_LSB +: 2] == 2'h3) ? 2'h2 : cfg_reg[CTRL_LANES_LSB +: 2];
  assign bits = 7'(16 << lm);

  sync_edge #(.W(5)) u_cap (
    .mclk_i   (mclk_i),
    .nrst_i   (nrst_i),
    .d_i      (cfg_reg[CTRL_DIFF_BIT] ? {link.pair_out_p, link.echo_p}
                                      : {link.lane_out, link.echoed_shift_clock}),
    .q_o      (cap_s),
    .q_prev_o (cap_p),
    .rise_o   (cap_r),
    .fall_o   (cap_f)
  );

  // Data one sample older than the edge, for hold margin
  // SDR captures on rising
  wire cap_go = (st_reg == H_CLOCK || st_reg == H_DRAIN) &&
                (cfg_reg[CTRL_RATE_BIT] ? (cap_r[0] || cap_f[0]) : cap_r[0]);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sr_reg <= 256'h0;
    end else if (cap_go) begin
      for (int j = 0; j < 4; j++) begin
        sr_reg[64*j +: 64] <= {sr_reg[64*j +: 63], cap_p[j+1]};
      end
    end
  end

  // ==========================================================
  // Frame sequencer
  logic [15:0] tmr_reg;
  logic [7:0]  edges_reg;
  logic        conv_reg;
  logic        strobe_reg;
  logic        sck_reg;
  wire         tmr_done = (tmr_reg == 16'h0);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      H_IDLE: begin
        if ((cmd_reg[CTRL_CONV_BIT] && !locked) || cmd_reg[CTRL_PULSE_BIT]) begin
          st_next = H_STROBE;
        end else if (cmd_reg[CTRL_WAKE_BIT]) begin
          st_next = H_WAKE;
        end
      end
      H_STROBE: if (tmr_done) st_next = conv_reg ? H_CONV : H_IDLE;
      H_CONV:   if (tmr_done) st_next = H_CLOCK;
      H_CLOCK:  if (tmr_done && edges_reg == 8'h1) st_next = H_DRAIN;
      H_DRAIN:  if (tmr_done) st_next = H_IDLE;
      default:  if (tmr_done && !sck_reg) st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg     <= H_IDLE;
      tmr_reg    <= 16'h0;
      edges_reg  <= 8'h0;
      conv_reg   <= 1'b0;
      strobe_reg <= 1'b0;
      sck_reg    <= 1'b0;
      res_reg    <= 64'h0;
      frames_reg <= 8'h0;
    end else begin
      st_reg  <= st_next;
      tmr_reg <= tmr_done ? 16'h0 : tmr_reg - 16'h1;
      case (st_reg)
        H_IDLE: begin
          conv_reg <= cmd_reg[CTRL_CONV_BIT] && !locked;
          if (st_next == H_STROBE) begin
            // high strobe for the fixed pulse width
            strobe_reg <= 1'b1;
            tmr_reg    <= 16'(STROBE_HIGH_CYC - 1);
          end else if (st_next == H_WAKE) begin
            sck_reg <= 1'b1;
            tmr_reg <= 16'(SCK_HALF_CYC - 1);
          end
        end
        H_STROBE: begin
          if (tmr_done) begin
            strobe_reg <= 1'b0;
            tmr_reg    <= 16'(CONV_WAIT_CYC - 1);
            // edges per frame from rate and lanes
            edges_reg  <= cfg_reg[CTRL_RATE_BIT] ? {1'b0, bits} : {bits, 1'b0};
          end
        end
        H_CONV: begin
          // First half period counts from the end of the wait
          if (tmr_done) begin
            tmr_reg <= 16'(SCK_HALF_CYC - 1);
          end
        end
        H_CLOCK: begin
          if (tmr_done) begin
            sck_reg   <= !sck_reg;
            edges_reg <= edges_reg - 8'h1;
            tmr_reg   <= 16'((edges_reg == 8'h1) ? DRAIN_CYC - 1 : SCK_HALF_CYC - 1);
          end
        end
        H_DRAIN: begin
          if (tmr_done) begin
            for (int c = 0; c < 4; c++) begin
              res_reg[16*c +: 16] <= word_of(sr_reg, 2'(c), lm);
            end
            frames_reg <= frames_reg + 8'h1;
          end
        end
        H_WAKE: begin
          if (tmr_done && sck_reg) begin
            sck_reg <= 1'b0;
            tmr_reg <= 16'(SCK_HALF_CYC - 1);
          end
        end
        default: begin
          tmr_reg <= 16'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // Configuration, commands and lockout
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_reg  <= CTRL_RST;
      cmd_reg  <= 3'h0;
      // no conversion until the wait has passed
      lock_reg <= 32'(LOCK_CYCLES);
    end else begin
      cfg_reg  <= ctrl_wr ? {wdata_reg[7:3], 3'h0} : cfg_reg;
      cmd_reg  <= ctrl_wr ? wdata_reg[2:0] : 3'h0;
      lock_reg <= (st_reg == H_WAKE && st_next == H_IDLE) ? 32'(LOCK_CYCLES)
                : (locked ? lock_reg - 32'h1 : 32'h0);
    end
  end

  // Pin drive by I/O standard
  assign link.convert_strobe_n = strobe_reg;
  assign link.shift_clock      = cfg_reg[CTRL_DIFF_BIT] ? 1'b0 : sck_reg;
  assign link.shift_clock_p    = cfg_reg[CTRL_DIFF_BIT] ? sck_reg : 1'b0;
  assign link.shift_clock_n    = cfg_reg[CTRL_DIFF_BIT] ? !sck_reg : 1'b0;
  assign link.rate_select      = cfg_reg[CTRL_RATE_BIT];
  assign link.echo_disable     = cfg_reg[CTRL_ECHO_BIT];
  assign link.io_select        = cfg_reg[CTRL_DIFF_BIT];

endmodule : adc_readout_host

// >>> hw/sync_edge.sv
// Two-flop synchroniser with edge pulses for a group of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/100ps
module sync_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  // Pins in, synchronised levels and edges out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] q_prev_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ==========================================================
  // Only s2 and s3 feed logic; s1 may be metastable
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Edge pulses last one cycle
  assign q_o      = s2_reg;
  assign q_prev_o = s3_reg;
  assign rise_o   = s2_reg & ~s3_reg;
  assign fall_o   = ~s2_reg & s3_reg;
endmodule : sync_edge

// >>> verification/adc_link_properties.sv
// Pin-level checker for the converter link between both design ends.
// Assumes plain wires from the link interface and one 200 MHz clock.
`timescale 1ns/100ps
module adc_link_properties (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  // Link pins
  input wire logic       convert_strobe_n,
  input wire logic       shift_clock,
  input wire logic       shift_clock_p,
  input wire logic       rate_select,
  input wire logic       echo_disable,
  input wire logic       io_select,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] pair_out_p,
  input wire logic [3:0] pair_out_n,
  input wire logic       echoed_shift_clock
);
  // ==========================================
  // Properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Six-cycle high strobe, then back low
  sequence strobe_pulse;
    convert_strobe_n [*6] ##1 !convert_strobe_n;
  endsequence
  // Echo lags the pin through the synchroniser
  sequence echo_rise;
    ##[2:5] $rose(echoed_shift_clock);
  endsequence
  chk_strobe_width: assert property ($rose(convert_strobe_n) |-> strobe_pulse)
    else $error("strobe pulse width wrong");
  chk_echo_rise: assert property (!io_select && !echo_disable && $rose(shift_clock) |-> echo_rise)
    else $error("echo missed a rising edge");
  chk_echo_fall: assert property (!io_select && !echo_disable && $fell(shift_clock) |-> ##[2:5] $fell(echoed_shift_clock))
    else $error("echo missed a falling edge");
  chk_sdr_hold: assert property (!rate_select && !io_select && $rose(echoed_shift_clock) |-> $stable(lane_out))
    else $error("lane moved on rising echo in single rate");
  chk_echo_off: assert property ((echo_disable) [*8] |-> !echoed_shift_clock)
    else $error("echo active while disabled");
  chk_no_own_clock: assert property ($rose(echoed_shift_clock) |-> $past(shift_clock, 3) || $past(shift_clock, 4))
    else $error("echo rose without shift clock");
  chk_se_quiet: assert property ((!io_select) [*8] |-> pair_out_p == 4'h0 && pair_out_n == 4'h0 && !shift_clock_p)
    else $error("differential pins active in single-ended mode");
  chk_diff_pairs: assert property ((io_select) [*8] |-> pair_out_n == ~pair_out_p && lane_out == 4'h0 && !shift_clock)
    else $error("differential pins wrong");
endmodule : adc_link_properties

// >>> verification/testbench.sv
// Top bench: both link ends joined, host driven over AXI4-Lite.
// Assumes short lockout and reinit counts set here.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module testbench;
  import adc_link_pkg::*;
  // ==========================================
  // Stimulus state
  localparam logic [9:0]  PW = {2'h0, 2'h2, 2'h1, 2'h1, 2'h0};
  localparam logic [39:0] MD = 40'h2048800800;
  logic mclk_i = 1'b0, nrst_i = 1'b0, sup = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [63:0] chd = 64'h8001_7FFE_C3A5_0F5A;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic bv, rv, awr, wrd, arr, busy;
  logic [1:0] bresp, rresp, r, pwr;
  int n_mismatch = 0, tests_run = 0, f = 0, k, c;
  // Half period of 2.5 ns
  always #2.5 mclk_i = ~mclk_i;
  adc_link_if lnk ();
  adc_readout_device #(.REINIT_CYCLES(200)) i_adc_readout_device (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .ch_data_i(chd), .supply_ok_i(sup), .power_state_o(pwr), .reinit_busy_o(busy), .link(lnk.device));
  adc_readout_host #(.LOCK_CYCLES(200)) i_adc_readout_host (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .link(lnk.host));
  adc_link_properties i_props (.mclk_i(mclk_i), .nrst_i(nrst_i), .convert_strobe_n(lnk.convert_strobe_n),
    .shift_clock(lnk.shift_clock), .shift_clock_p(lnk.shift_clock_p), .rate_select(lnk.rate_select),
    .echo_disable(lnk.echo_disable), .io_select(lnk.io_select), .lane_out(lnk.lane_out),
    .pair_out_p(lnk.pair_out_p), .pair_out_n(lnk.pair_out_n), .echoed_shift_clock(lnk.echoed_shift_clock));
  // ==========================================
  // Bus tasks
  task automatic results;
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic wr(input logic [31:0] v);
    int n;
    aw <= CTRL_OFS; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    // Sample only after an edge
    for (n = 0; n < 100; n++) begin
      @(posedge mclk_i);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    if (n == 100) begin n_mismatch++; results(); end
    `CHK("bresp", RESP_OKAY, bresp)
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    ar <= a; arv <= 1'b1; rr <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk_i);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    d = rdat; r = rresp;
    if (n == 100) begin n_mismatch++; results(); end
  endtask : rd
  // Status poll; a stuck status ends the run
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 1000; n++) begin rd(STATUS_OFS); if ((d & m) === v) break; end
    if (n == 1000) begin n_mismatch++; results(); end
  endtask : poll
  task automatic pulses(input int m);
    repeat (m) begin wr(32'h2); repeat (40) @(posedge mclk_i); end
  endtask : pulses
  // ==========================================
  // Scenarios
  initial begin
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    rd(STATUS_OFS); `CHK("lock", 1'b1, d[STAT_LOCK_BIT])
    rd(CTRL_OFS); `CHK("ctrl", 32'(CTRL_RST), d)
    rd(8'h40); `CHK("resp", RESP_SLVERR, r)
    poll(32'h2, 32'h0);
    // Every rate, lane count and I/O standard
    for (k = 0; k < 5; k++) begin
      chd <= {chd[47:0], chd[63:48]} ^ 64'h1111_2222_4444_8888;
      wr(32'(MD[8*k +: 8]) | 32'h1);
      f++;
      poll(32'hFF00, 32'(f) << 8);
      for (c = 0; c < 4; c++) begin
        rd(RESULT_OFS + 8'(4 * c)); `CHK("result", chd[16*c +: 16], d[15:0])
      end
    end
    wr(32'h11); f++; poll(32'hFF00, 32'(f) << 8);
    for (k = 0; k < 10; k++) begin
      pulses(1); `CHK("power", PW[2*(k%5) +: 2], pwr)
    end
    pulses(2); wr(32'h4); repeat (40) @(posedge mclk_i); `CHK("nap wake", 2'h0, pwr)
    pulses(4); wr(32'h4); repeat (40) @(posedge mclk_i); `CHK("sleep wake", 2'h0, pwr)
    rd(STATUS_OFS); `CHK("relock", 1'b1, d[STAT_LOCK_BIT])
    sup <= 1'b0; repeat (20) @(posedge mclk_i); `CHK("drop", 1'b1, busy)
    sup <= 1'b1;
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge mclk_i);
    `CHK("reinit", 1'b0, busy)
    results();
  end
endmodule : testbench
